// [verilog/display_params.svh]
// Timing counts, field values and strap codes for the display panel link
`ifndef DISPLAY_PARAMS_SVH
`define DISPLAY_PARAMS_SVH
`define CLK_NS        100
`define GRID_ON_US    427
`define SCAN_US       5368
`define NUM_GRIDS     11
`define WD_MS         4750
`define WD_RST_US     460
`define POR_US        1000
`define TONE_HZ       3600
`define PROC_CYC      8'h10
`define INIT_WAIT     8'h03
`define ST_PASS       8'h01
`define ST_FAIL       8'h55
`define RESP_IDLE     8'h00
`define CTRL_BIT      7
`define PAT_OFF       14'h0000
`define PAT_ON        14'h3FFF
`define PAT_T1        14'h1555
`define PAT_T2        14'h2AAA
`define LINK_HALF     8'h08
`define HOST_GUARD    8'h10
`define KEY_DWELL     16'h0100
`endif

// [verilog/display_pkg.sv]
// Types for both ends of the display panel link, and gray-code helpers used by the display end
`default_nettype none
package display_pkg;
  // Device controller states
  typedef enum logic [3:0]
  {
    DEV_INIT = 4'b0001,
    DEV_TEST = 4'b0010,
    DEV_IDLE = 4'b0100,
    DEV_PROC = 4'b1000
  } dev_state_t;
  // Host link states
  typedef enum logic [3:0]
  {
    HST_IDLE  = 4'b0001,
    HST_WAIT  = 4'b0010,
    HST_SHIFT = 4'b0100,
    HST_GUARD = 4'b1000
  } host_state_t;
  // Binary to gray, for counters that cross domains
  function automatic logic [2:0] bin2gray(input logic [2:0] b);
    return b ^ (b >> 1);
  endfunction
  // Gray back to binary
  function automatic logic [2:0] gray2bin(input logic [2:0] g);
    return {g[2], g[2] ^ g[1], g[2] ^ g[1] ^ g[0]};
  endfunction
endpackage
`default_nettype wire

// [verilog/display_link_if.sv]
// Three-wire command link plus key-matrix lines between host and display
`default_nettype none
interface display_link_if;
  logic       displayLinkClock;  // Link clock, made by host
  logic       displayCmdIn;      // Command bits, host to display
  logic       displayRespOut;    // Response and busy, display to host
  logic [5:0] keyLineOut;        // Host drive level per key line
  logic [5:0] keyLineOe;         // Host drive enable per key line
  logic [5:0] keyPulled;         // Lines pulled low by closed switches
  logic [5:0] keyLineIn;         // Resolved key line level
  // Pull-ups win unless driven or shorted low
  assign keyLineIn = (~keyLineOe | keyLineOut) & ~keyPulled;
  modport dev (input displayLinkClock, input displayCmdIn, output displayRespOut);
  modport host (output displayLinkClock, output displayCmdIn, input displayRespOut,
                output keyLineOut, output keyLineOe, input keyLineIn);
endinterface
`default_nettype wire

// [verilog/display_panel_ctrl.sv]
// Display end: serial command link, grid scan, watchdog reset and beeper
// Function
// - Command bit sampled on link clock rise
// - Response bits change on link clock fall
// - Response high while processing; host waits
// - Self-test and memory init, then line low
// - First byte answers 01h pass, 55h fail
// - Two active-low straps pick power-up pattern
// - Ten grids, fourteen anodes, eleventh grid port
// - Grids one at a time, 0 to 10
// - Grid on 427 us, scan 5.368 ms
// - Grid off, then anodes, then grid on
// - Segment lit only with anode and grid
// - Host step one reads all key lines
// - Host strobes lines 1 to 5 low
// - Host decodes 19 switches by table
// - Both reset polarities at power-up and timeout
// - Watchdog restarts on command input rise
// - Timeout gives 460 us reset, then rearm
// - 3.6 kHz square tone while beeping
`include "display_params.svh"
`default_nettype none
module display_panel_ctrl
  import display_pkg::*;
#(
  parameter int unsigned GRID_ON = `GRID_ON_US * 1000 / `CLK_NS,
  parameter int unsigned SLOT    = `SCAN_US * 1000 / (`NUM_GRIDS * `CLK_NS),
  parameter int unsigned WD_CYC  = `WD_MS * (1000000 / `CLK_NS),
  parameter int unsigned WDR_CYC = `WD_RST_US * 1000 / `CLK_NS,
  parameter int unsigned POR_CYC = `POR_US * 1000 / `CLK_NS,
  parameter int unsigned TONE_HALF = 1000000000 / (`CLK_NS * 2 * `TONE_HZ)
)
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Link to host
  display_link_if.dev      link,
  // Straps and self-test input
  input  wire logic        patternSelectN,
  input  wire logic        lampSelectN,
  input  wire logic        selfTestFault,
  // Display drive
  output var  logic [9:0]  gridOut,
  output var  logic        lastGridPort,
  output var  logic [13:0] anodeOut,
  output var  logic        toneOutput,
  // System reset
  output var  logic        sysReset,
  output var  logic        sysResetN
);

  ////////////////////////////////////////////////////////////////////////
  // Link-domain state
  typedef struct packed {
    logic [7:0] shift;   // Incoming bits
    logic [2:0] cnt;     // Bit within byte
    logic [7:0] rxByte;  // Last whole byte
    logic       rxTog;   // Flips per byte
  } link_t;
  link_t      lk_reg, lk_next;
  logic [2:0] negGray_reg;  // Falling-edge count, gray coded

  // Shift on rise, eight bits a byte
  always_comb
  begin
    lk_next = lk_reg;
    lk_next.shift = {lk_reg.shift[6:0], link.displayCmdIn};
    lk_next.cnt = lk_reg.cnt + 3'h1;
    if (lk_reg.cnt == 3'h7)
    begin
      lk_next.rxByte = {lk_reg.shift[6:0], link.displayCmdIn};
      lk_next.rxTog = ~lk_reg.rxTog;
    end
  end

  // Rising edge register
  always_ff @(posedge link.displayLinkClock or negedge rst_n)
  begin
    if (!rst_n)
      lk_reg <= '0;
    else
      lk_reg <= lk_next;
  end

  // Falling edges advance the response bit pointer
  always_ff @(negedge link.displayLinkClock or negedge rst_n)
  begin
    if (!rst_n)
      negGray_reg <= 3'h0;
    else
      negGray_reg <= bin2gray(gray2bin(negGray_reg) + 3'h1);
  end

  ////////////////////////////////////////////////////////////////////////
  // Core-domain state
  typedef struct packed {
    dev_state_t        st;          // Controller state
    logic [7:0]        waitCnt;     // Init and busy timer
    logic [3:0]        initIdx;     // Memory init pointer
    logic [10:0][13:0] mem;         // Anode data per grid
    logic [7:0]        respByte;    // Byte to shift out
    logic [1:0]        phase;       // Position in grid write
    logic [3:0]        tgtGrid;     // Grid being written
    logic [7:0]        dataLo;      // Low anode byte
    logic              beepOn;      // Beeper commanded
    logic [1:0]        togSync;     // Byte toggle sync
    logic              togSeen;     // Last toggle handled
    logic [2:0]        grayS1;      // Pointer sync, first
    logic [2:0]        grayS2;      // Pointer sync, second
    logic [1:0][7:0]   bufData;     // Two-entry byte buffer
    logic [1:0]        bufCnt;      // Buffer fill
    logic [3:0]        strapSync;   // Straps, two stages
    logic [1:0]        faultSync;   // Fault input sync
    logic [1:0]        cmdSync;     // Command pin sync
    logic              cmdPrev;     // For rise detect
    logic [31:0]       gridCnt;     // Time within slot
    logic [3:0]        gridIdx;     // Active grid
    logic [9:0]        grid;        // Grid drive
    logic              lastGrid;    // Eleventh grid drive
    logic [13:0]       anode;       // Anode drive
    logic [31:0]       wdCnt;       // Watchdog timer
    logic [31:0]       rstCnt;      // Reset pulse timer
    logic              porDone;     // Power-on delay over
    logic              sysRst;      // Reset high
    logic              sysRstN;     // Reset low
    logic [31:0]       toneCnt;     // Tone half period
    logic              tone;        // Tone level
    logic              resp;        // Response line
  } core_t;
  core_t core_reg, core_next;

  // Pattern for one grid from the straps
  function automatic logic [13:0] initPattern(input logic [1:0] s, input logic odd);
    case (s)
      2'b11:   initPattern = `PAT_OFF;
      2'b10:   initPattern = `PAT_ON;
      2'b01:   initPattern = odd ? `PAT_T2 : `PAT_T1;
      default: initPattern = odd ? `PAT_T1 : `PAT_T2;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Core next-state logic
  always_comb
  begin
    logic       push;
    logic       busy;
    logic [7:0] b;
    logic [2:0] ptr;
    core_next = core_reg;
    push = 1'b0;
    busy = 1'b0;
    b = core_reg.bufData[0];
    ptr = gray2bin(core_reg.grayS2);
    // Synchronisers
    core_next.togSync = {core_reg.togSync[0], lk_reg.rxTog};
    core_next.grayS1 = negGray_reg;
    core_next.grayS2 = core_reg.grayS1;
    core_next.strapSync = {core_reg.strapSync[1:0], patternSelectN, lampSelectN};
    core_next.faultSync = {core_reg.faultSync[0], selfTestFault};
    core_next.cmdSync = {core_reg.cmdSync[0], link.displayCmdIn};
    core_next.cmdPrev = core_reg.cmdSync[1];
    // New byte into the buffer
    if (core_reg.togSync[1] != core_reg.togSeen)
    begin
      push = 1'b1;
      core_next.togSeen = core_reg.togSync[1];
      if (core_reg.bufCnt != 2'h2)
      begin
        core_next.bufData[core_reg.bufCnt[0]] = lk_reg.rxByte;
        core_next.bufCnt = core_reg.bufCnt + 2'h1;
      end
    end
    // Controller sequence
    case (core_reg.st)
      DEV_INIT:
      begin
        if (core_reg.waitCnt != `INIT_WAIT)
          core_next.waitCnt = core_reg.waitCnt + 8'h01;
        else
        begin
          core_next.mem[core_reg.initIdx] =
            initPattern(core_reg.strapSync[3:2], core_reg.initIdx[0]);
          core_next.initIdx = core_reg.initIdx + 4'h1;
          if (core_reg.initIdx == 4'(`NUM_GRIDS - 1))
          begin
            core_next.waitCnt = 8'h00;
            core_next.st = DEV_TEST;
          end
        end
      end
      DEV_TEST:
      begin
        core_next.waitCnt = core_reg.waitCnt + 8'h01;
        if (core_reg.waitCnt == `PROC_CYC)
        begin
          core_next.respByte = core_reg.faultSync[1] ? `ST_FAIL : `ST_PASS;
          core_next.st = DEV_IDLE;
        end
      end
      DEV_IDLE:
      begin
        if (core_reg.bufCnt != 2'h0)
        begin
          // Pop the oldest byte and act on it
          core_next.bufData[0] = core_next.bufData[1];
          core_next.bufCnt = core_next.bufCnt - 2'h1;
          core_next.waitCnt = 8'h00;
          core_next.respByte = `RESP_IDLE;
          core_next.st = DEV_PROC;
          if (b[`CTRL_BIT] && core_reg.phase == 2'h0)
            core_next.beepOn = b[0];
          else if (core_reg.phase == 2'h0)
          begin
            core_next.tgtGrid = b[3:0];
            core_next.phase = 2'h1;
          end
          else if (core_reg.phase == 2'h1)
          begin
            core_next.dataLo = b;
            core_next.phase = 2'h2;
          end
          else
          begin
            if (core_reg.tgtGrid < 4'(`NUM_GRIDS))
              core_next.mem[core_reg.tgtGrid] = {b[5:0], core_reg.dataLo};
            core_next.phase = 2'h0;
          end
        end
      end
      DEV_PROC:
      begin
        core_next.waitCnt = core_reg.waitCnt + 8'h01;
        if (core_reg.waitCnt == `PROC_CYC)
          core_next.st = DEV_IDLE;
      end
      default:
        core_next.st = DEV_INIT;
    endcase
    // Busy while working or holding bytes
    busy = (core_reg.st != DEV_IDLE) || (core_reg.bufCnt != 2'h0) || push;
    core_next.resp = busy ? 1'b1 : core_reg.respByte[3'h7 - ptr];
    // Grid multiplex
    core_next.gridCnt = core_reg.gridCnt + 32'h1;
    if (core_reg.gridCnt == 32'h0)
      core_next.anode = core_reg.mem[core_reg.gridIdx];
    else if (core_reg.gridCnt == 32'h1)
    begin
      core_next.grid = 10'(11'h001 << core_reg.gridIdx);
      core_next.lastGrid = (core_reg.gridIdx == 4'(`NUM_GRIDS - 1));
    end
    else if (core_reg.gridCnt == GRID_ON + 1)
    begin
      core_next.grid = 10'h000;
      core_next.lastGrid = 1'b0;
    end
    if (core_reg.gridCnt == SLOT - 1)
    begin
      core_next.gridCnt = 32'h0;
      core_next.gridIdx = (core_reg.gridIdx == 4'(`NUM_GRIDS - 1)) ? 4'h0
                          : core_reg.gridIdx + 4'h1;
    end
    // Power-on delay and watchdog
    if (core_reg.sysRst)
    begin
      core_next.rstCnt = core_reg.rstCnt + 32'h1;
      core_next.wdCnt = 32'h0;
      if (core_reg.rstCnt == (core_reg.porDone ? WDR_CYC : POR_CYC) - 1)
      begin
        core_next.sysRst = 1'b0;
        core_next.porDone = 1'b1;
      end
    end
    else if (core_reg.cmdSync[1] && !core_reg.cmdPrev)
      core_next.wdCnt = 32'h0;
    else if (core_reg.wdCnt == WD_CYC - 1)
    begin
      core_next.sysRst = 1'b1;
      core_next.rstCnt = 32'h0;
    end
    else
      core_next.wdCnt = core_reg.wdCnt + 32'h1;
    core_next.sysRstN = ~core_next.sysRst;
    // Beeper tone
    if (!core_reg.beepOn)
    begin
      core_next.toneCnt = 32'h0;
      core_next.tone = 1'b0;
    end
    else if (core_reg.toneCnt == TONE_HALF - 1)
    begin
      core_next.toneCnt = 32'h0;
      core_next.tone = ~core_reg.tone;
    end
    else
      core_next.toneCnt = core_reg.toneCnt + 32'h1;
  end

  // Core register
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      core_reg <= '0;
      core_reg.st <= DEV_INIT;
      core_reg.resp <= 1'b1;
      core_reg.sysRst <= 1'b1;
    end
    else
      core_reg <= core_next;
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs straight from flops
  assign gridOut = core_reg.grid;
  assign lastGridPort = core_reg.lastGrid;
  assign anodeOut = core_reg.anode;
  assign toneOutput = core_reg.tone;
  assign sysReset = core_reg.sysRst;
  assign sysResetN = core_reg.sysRstN;
  assign link.displayRespOut = core_reg.resp;

endmodule
`default_nettype wire

// [verilog/display_host.sv]
// Host end: sends command bytes, collects responses, scans the key matrix
`include "display_params.svh"
`default_nettype none
module display_host
  import display_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Link to display
  display_link_if.host     link,
  // Command stream
  input  wire logic [7:0]  txData,
  input  wire logic        txValid,
  output var  logic        txReady,
  // Response stream
  output var  logic [7:0]  rxData,
  output var  logic        rxValid,
  // Key states
  output var  logic [18:0] keysDown
);

  ////////////////////////////////////////////////////////////////////////
  // All host state
  typedef struct packed {
    host_state_t st;        // Link state
    logic [7:0]  divCnt;    // Half period and guard timer
    logic [3:0]  bitCnt;    // Rises sent
    logic [7:0]  tx;        // Outgoing byte
    logic [7:0]  rx;        // Incoming byte
    logic        sclk;      // Link clock level
    logic        cmd;       // Command line level
    logic [1:0]  respSync;  // Response sync
    logic        ready;     // Accepting a byte
    logic [7:0]  rxOut;     // Last response
    logic        rxV;       // Response pulse
    logic [2:0]  keyStep;   // Scan step 0..5
    logic [15:0] keyCnt;    // Dwell timer
    logic [5:0]  keyOut;    // Line drive levels
    logic [5:0]  keyOe;     // Line drive enables
    logic [5:0]  keyS1;     // Line sync, first
    logic [5:0]  keyS2;     // Line sync, second
    logic [18:0] keyAcc;    // Keys this pass
    logic [18:0] keys;      // Keys, last whole pass
  } host_t;
  host_t h_reg, h_next;

  // Switch closures seen on one step
  function automatic logic [18:0] keyDecode(input logic [2:0] s, input logic [5:0] ln);
    logic [5:0]  p;
    logic [18:0] k;
    p = ~ln;
    k = 19'h00000;
    case (s)
      3'h0: {k[7], k[16], k[9], k[11], k[17], k[12]} = p;
      3'h1: {k[0], k[1], k[2], k[3], k[10]} = p[5:1];
      3'h2: {k[6], k[8], k[4], k[5]} = p[5:2];
      3'h3: {k[13], k[14], k[15]} = p[5:3];
      3'h5: k[18] = p[5];
      default: k = 19'h00000;
    endcase
    return k;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb
  begin
    h_next = h_reg;
    h_next.respSync = {h_reg.respSync[0], link.displayRespOut};
    h_next.rxV = 1'b0;
    h_next.divCnt = h_reg.divCnt + 8'h01;
    case (h_reg.st)
      HST_IDLE:
      begin
        if (txValid && h_reg.ready)
        begin
          h_next.tx = txData;
          h_next.ready = 1'b0;
          h_next.st = HST_WAIT;
        end
      end
      HST_WAIT:
      begin
        // Hold off while the display is busy
        h_next.divCnt = 8'h00;
        h_next.bitCnt = 4'h0;
        if (!h_reg.respSync[1])
        begin
          h_next.cmd = h_reg.tx[7];
          h_next.st = HST_SHIFT;
        end
      end
      HST_SHIFT:
      begin
        if (h_reg.divCnt == `LINK_HALF - 8'h01)
        begin
          h_next.divCnt = 8'h00;
          h_next.sclk = ~h_reg.sclk;
          if (!h_reg.sclk)
          begin
            // Rise: display takes the bit, response sampled
            h_next.rx = {h_reg.rx[6:0], h_reg.respSync[1]};
            h_next.bitCnt = h_reg.bitCnt + 4'h1;
          end
          else if (h_reg.bitCnt == 4'h8)
          begin
            h_next.rxOut = h_reg.rx;
            h_next.rxV = 1'b1;
            h_next.st = HST_GUARD;
          end
          else
          begin
            h_next.tx = {h_reg.tx[6:0], 1'b0};
            h_next.cmd = h_reg.tx[6];
          end
        end
      end
      HST_GUARD:
      begin
        // Let the busy level come back before the next byte
        if (h_reg.divCnt == `HOST_GUARD)
        begin
          h_next.cmd = 1'b0;
          h_next.ready = 1'b1;
          h_next.st = HST_IDLE;
        end
      end
      default:
        h_next.st = HST_IDLE;
    endcase
    // Key matrix scan
    h_next.keyS1 = link.keyLineIn;
    h_next.keyS2 = h_reg.keyS1;
    h_next.keyCnt = h_reg.keyCnt + 16'h0001;
    if (h_reg.keyCnt == `KEY_DWELL)
    begin
      h_next.keyCnt = 16'h0000;
      h_next.keyAcc = h_reg.keyAcc | keyDecode(h_reg.keyStep, h_reg.keyS2);
      h_next.keyStep = (h_reg.keyStep == 3'h5) ? 3'h0 : h_reg.keyStep + 3'h1;
      if (h_reg.keyStep == 3'h5)
      begin
        h_next.keys = h_next.keyAcc;
        h_next.keyAcc = 19'h00000;
      end
      h_next.keyOe = (h_next.keyStep == 3'h0) ? 6'h00
                     : 6'(7'h01 << (h_next.keyStep - 3'h1));
    end
  end

  // Host register
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      h_reg <= '0;
      h_reg.st <= HST_IDLE;
      h_reg.ready <= 1'b1;
      h_reg.respSync <= 2'h3;
    end
    else
      h_reg <= h_next;
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs straight from flops
  assign link.displayLinkClock = h_reg.sclk;
  assign link.displayCmdIn = h_reg.cmd;
  assign link.keyLineOut = h_reg.keyOut;
  assign link.keyLineOe = h_reg.keyOe;
  assign txReady = h_reg.ready;
  assign rxData = h_reg.rxOut;
  assign rxValid = h_reg.rxV;
  assign keysDown = h_reg.keys;

endmodule
`default_nettype wire

// [tb/display_link_assertions.sv]
// Checker for the link wires, grid scan, tone and reset outputs
`default_nettype none
module display_link_assertions
(
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst_n,
  // Link wires
  input wire logic        displayLinkClock,
  input wire logic        displayCmdIn,
  input wire logic        displayRespOut,
  // Display drive and system reset
  input wire logic [9:0]  gridOut,
  input wire logic        lastGridPort,
  input wire logic [13:0] anodeOut,
  input wire logic        toneOutput,
  input wire logic        sysReset,
  input wire logic        sysResetN
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [10:0] gridVec;      // All eleven grid drives
  logic [10:0] lastOn_reg;   // Last grid seen on
  logic [2:0]  riseCnt_reg;  // Link clock rises in frame
  logic        linkClk_reg;  // Link clock one cycle back
  assign gridVec = {lastGridPort, gridOut};
  ////////////////////////////////////////////////////////////////////////////////
  // Frame and scan tracking
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lastOn_reg  <= 11'h000;
      riseCnt_reg <= 3'h0;
      linkClk_reg <= 1'b0;
    end
    else
    begin
      linkClk_reg <= displayLinkClock;
      if (displayLinkClock && !linkClk_reg)
        riseCnt_reg <= riseCnt_reg + 3'h1;
      if (|gridVec)
        lastOn_reg <= gridVec;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  property p_cmdStable;
    $rose(displayLinkClock) |-> $stable(displayCmdIn);
  endproperty
  a_cmdStable: assert property (p_cmdStable)
    else $error("command bit moved at link clock rise");
  property p_respHold;
    displayLinkClock && $past(displayLinkClock) |-> !$fell(displayRespOut);
  endproperty
  a_respHold: assert property (p_respHold)
    else $error("response moved while link clock high");
  property p_noStart;
    $rose(displayLinkClock) && riseCnt_reg == 3'h0 |-> !displayRespOut;
  endproperty
  a_noStart: assert property (p_noStart)
    else $error("frame began while busy");
  property p_busyAfter;
    $rose(displayLinkClock) && riseCnt_reg == 3'h7 |-> ##[1:8] displayRespOut [*8];
  endproperty
  a_busyAfter: assert property (p_busyAfter)
    else $error("no busy after eighth rise");
  property p_initBusy;
    $rose(rst_n) |-> displayRespOut [*8];
  endproperty
  a_initBusy: assert property (p_initBusy)
    else $error("response low too soon after reset");
  property p_oneGrid;
    $onehot0(gridVec);
  endproperty
  a_oneGrid: assert property (p_oneGrid)
    else $error("more than one grid on");
  property p_gridOrder;
    $rose(|gridVec) |->
      gridVec == ((lastOn_reg == 11'h000 || lastOn_reg[10]) ? 11'h001 : lastOn_reg << 1);
  endproperty
  a_gridOrder: assert property (p_gridOrder)
    else $error("grid out of order");
  property p_anodeHold;
    (|gridVec) && $past(|gridVec) |-> $stable(anodeOut);
  endproperty
  a_anodeHold: assert property (p_anodeHold)
    else $error("anodes changed under a lit grid");
  property p_porReset;
    $rose(rst_n) |-> (sysReset && !sysResetN) [*8];
  endproperty
  a_porReset: assert property (p_porReset)
    else $error("system reset not held after power up");
  property p_toneHalf;
    $fell(toneOutput) |-> !toneOutput [*4];
  endproperty
  a_toneHalf: assert property (p_toneHalf)
    else $error("tone half period wrong");
  c_frame: cover property ($rose(displayLinkClock) && riseCnt_reg == 3'h7);
  c_tone: cover property ($rose(toneOutput));
  c_wdog: cover property ($rose(sysReset));
endmodule
`default_nettype wire

// [tb/testbench.sv]
// Bench joining host and display ends over the link
`include "display_params.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [13:0] PAT_TAB [4] = '{`PAT_OFF, `PAT_ON, `PAT_T1, `PAT_T2};
  logic        core_clk = 1'b0;        // Core clock
  logic        rst_n = 1'b0;           // Reset, active low
  logic        patternSelectN = 1'b1;  // Pattern strap
  logic        lampSelectN = 1'b0;     // Lamp strap
  logic        selfTestFault = 1'b0;   // Failing self-test
  logic [7:0]  txData = 8'h00;         // Command byte
  logic        txValid = 1'b0;         // Command offered
  logic        txReady, rxValid, lastGridPort, toneOutput, sysReset, sysResetN;
  logic [7:0]  rxData;                 // Response byte
  logic [18:0] keysDown;               // Decoded switches
  logic [9:0]  gridOut;                // Grids 0 to 9
  logic [10:0] gridVec;                // All grids
  logic [13:0] anodeOut;               // Anode pattern
  logic [7:0]  expQ [$];               // Expected responses
  logic        firstByte;              // Next answer is self-test
  int          errors = 0;
  int          samples_checked = 0;
  assign gridVec = {lastGridPort, gridOut};
  display_link_if linkBus();
  display_panel_ctrl #(.GRID_ON(10), .SLOT(20), .WD_CYC(2000), .WDR_CYC(50),
    .POR_CYC(30)) display_panel_ctrl_i
  (
    .core_clk(core_clk), .rst_n(rst_n), .link(linkBus), .patternSelectN(patternSelectN),
    .lampSelectN(lampSelectN), .selfTestFault(selfTestFault), .gridOut(gridOut),
    .lastGridPort(lastGridPort), .anodeOut(anodeOut), .toneOutput(toneOutput),
    .sysReset(sysReset), .sysResetN(sysResetN)
  );
  display_host display_host_i
  (
    .core_clk(core_clk), .rst_n(rst_n), .link(linkBus), .txData(txData),
    .txValid(txValid), .txReady(txReady), .rxData(rxData), .rxValid(rxValid),
    .keysDown(keysDown)
  );
  display_link_assertions checker_i
  (
    .core_clk(core_clk), .rst_n(rst_n), .displayLinkClock(linkBus.displayLinkClock),
    .displayCmdIn(linkBus.displayCmdIn), .displayRespOut(linkBus.displayRespOut),
    .gridOut(gridOut), .lastGridPort(lastGridPort), .anodeOut(anodeOut),
    .toneOutput(toneOutput), .sysReset(sysReset), .sysResetN(sysResetN)
  );
  always #50 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Compare one value
  task automatic check(input logic [18:0] got, input logic [18:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Reset both ends with given straps
  task automatic doReset(input logic [1:0] straps, input logic fault);
    @(negedge core_clk);
    rst_n <= 1'b0;
    {patternSelectN, lampSelectN} <= straps;
    selfTestFault <= fault;
    expQ.delete();
    firstByte = 1'b1;
    repeat (5) @(negedge core_clk);
    rst_n <= 1'b1;
  endtask
  // Offer one byte, held until taken, and note its answer
  task automatic send(input logic [7:0] d);
    @(negedge core_clk);
    txData <= d;
    txValid <= 1'b1;
    for (int n = 0; n < 3000 && txReady !== 1'b1; n++)
      @(negedge core_clk);
    if (txReady !== 1'b1)
      errors++;
    @(posedge core_clk);
    expQ.push_back(firstByte ? (selfTestFault ? `ST_FAIL : `ST_PASS) : `RESP_IDLE);
    firstByte = 1'b0;
  endtask
  // Drop valid and wait for all answers
  task automatic waitIdle();
    @(negedge core_clk);
    txValid <= 1'b0;
    for (int n = 0; n < 20000 && (expQ.size() != 0 || txReady !== 1'b1); n++)
      @(negedge core_clk);
    check(19'(expQ.size()), 19'h00000);
  endtask
  // Wait for one grid lit and check its anodes
  task automatic gridChk(input int idx, input logic [13:0] exp);
    for (int n = 0; n < 1000 && gridVec[idx] !== 1'b1; n++)
      @(negedge core_clk);
    check(19'(anodeOut), 19'(exp));
  endtask
  // Each response against the oldest note
  always @(negedge core_clk)
  begin
    if (rxValid === 1'b1)
      check(19'(rxData), (expQ.size() != 0) ? 19'(expQ.pop_front()) : 19'h7FFFF);
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Hang guard
  initial
  begin
    #4000000;
    errors++;
    close_out();
  end
  // Test sequence
  initial
  begin
    logic [13:0] pat;
    logic [3:0]  grid;
    int          cnt;
    linkBus.keyPulled = 6'h00;
    void'($urandom(61));
    for (int i = 0; i < 4; i++)
    begin
      doReset(2'(3 - i), i == 3);
      send(8'h80);
      send(8'h80);
      waitIdle();
      gridChk(0, PAT_TAB[i]);
      $display("Strap and self-test case %0d done", i);
    end
    for (int k = 0; k < 2; k++)
    begin
      grid = (k == 0) ? 4'($urandom % 10) : 4'hA;
      pat = 14'($urandom);
      send({4'h0, grid});
      send(pat[7:0]);
      send({2'h0, pat[13:8]});
      waitIdle();
      repeat (250) @(negedge core_clk);
      gridChk(int'(grid), pat);
    end
    $display("Grid write test done");
    send(8'h81);
    waitIdle();
    for (int n = 0; n < 1500 && toneOutput !== 1'b1; n++)
      @(negedge core_clk);
    check(19'(toneOutput), 19'h00001);
    send(8'h80);
    waitIdle();
    repeat (10) @(negedge core_clk);
    check(19'(toneOutput), 19'h00000);
    $display("Tone test done");
    for (int k = 0; k < 2; k++)
    begin
      linkBus.keyPulled = (k == 0) ? 6'h01 : 6'h20;
      repeat (3200) @(negedge core_clk);
      check(keysDown, (k == 0) ? 19'h01000 : 19'h420C1);
    end
    linkBus.keyPulled = 6'h00;
    $display("Key scan test done");
    for (int n = 0; n < 100 && sysReset !== 1'b0; n++)
      @(negedge core_clk);
    for (int n = 0; n < 3000 && sysReset !== 1'b1; n++)
      @(negedge core_clk);
    cnt = 0;
    while (sysReset === 1'b1 && cnt < 100)
    begin
      @(negedge core_clk);
      cnt++;
    end
    check(19'(cnt), 19'h00032);
    $display("Watchdog test done");
    close_out();
  end
endmodule
`default_nettype wire
